// ### bench/sbf_remote.sv
// Purpose: Remote station on the serial line
// Assumes: Link clock runs free, line idles marking
// Notes: Keeps simple bit statistics, plays one frame on rxd
`timescale 1ns/1ps
`default_nettype none
`include "sbf_map.svh"
module sbf_remote (
  input wire logic clr, // Clear statistics
  input wire logic txd, // Line from framer
  input wire logic rx_go, // Play the frame once
  input wire logic [31:0] rx_pat, // Frame bits, bit 0 first
  output var logic lclk, // Link clock
  output var logic rxd, // Line to framer
  output var logic [4:0] max_run, // Longest run of ones
  output var logic flag_seen // Flag pattern seen
);
  logic [4:0] run;
  logic [4:0] nr;
  logic [7:0] sh;
  logic [5:0] bi;
  // ===================================================================
  // Clock and idle line
  // Sync link: clock free running so flags keep flowing
  initial begin
    lclk = 1'b0;
    forever #200 lclk = ~lclk;
  end
  // Frame bits change on the fall, settled well before the rise
  always @(negedge lclk) begin
    if (!rx_go) begin
      bi <= 6'h00;
      rxd <= 1'b1;
    end else if (bi < 6'd32) begin
      rxd <= rx_pat[bi[4:0]];
      bi <= bi + 6'h01;
    end else begin
      rxd <= 1'b1;
    end
  end
  // ===================================================================
  // Line monitor
  // Mid-bit sampling; txd moves about half a period after the fall
  always @(negedge lclk) begin
    nr = txd ? ((run == 5'h1f) ? run : run + 5'h01) : 5'h00;
    if (clr) begin
      run <= 5'h00;
      max_run <= 5'h00;
      flag_seen <= 1'b0;
      sh <= 8'hff;
    end else begin
      run <= nr;
      if (nr > max_run) max_run <= nr;
      sh <= {txd, sh[7:1]}; // Bits arrive low first
      if ({txd, sh[7:1]} == `SBF_FLAG_RST) flag_seen <= 1'b1;
    end
  end
endmodule : sbf_remote
`default_nettype wire

// ### bench/tb_sbf_framer.sv
// Purpose: Self-checking bench of the bit framer
// Assumes: Registers reached over Avalon-MM, remote model on the line
// Notes: One task per scenario, judged before it returns
`timescale 1ns/1ps
`default_nettype none
`include "sbf_map.svh"
module tb_sbf_framer;
  import sbf_pkg::*;
  logic clk, nrst, avs_read, avs_write, clr, ok;
  logic [5:0] avs_address;
  sbf_word_t avs_writedata, avs_readdata;
  logic avs_waitrequest, lclk, rxd, txd, rts_n, dtr_n, tx_irq, flag_seen;
  logic [4:0] max_run;
  logic rx_go;
  logic [31:0] rx_pat;
  logic [7:0] rd;
  int fails, tests_run;
  // ===================================================================
  // Design and remote station
  sbf_framer uut (.clk(clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'h1),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .lclk(lclk), .rxd(rxd),
    .txd(txd), .rts_n(rts_n), .dtr_n(dtr_n), .tx_irq(tx_irq));
  sbf_remote peer (.clr(clr), .txd(txd), .rx_go(rx_go), .rx_pat(rx_pat),
    .lclk(lclk), .rxd(rxd),
    .max_run(max_run), .flag_seen(flag_seen));
  // ===================================================================
  // Helpers
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk_bit(input string what, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %b seen %b", what, e, g);
    end
  endtask : chk_bit
  task automatic chk_byte(input string what, input logic [7:0] e,
                          input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk_byte
  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] idx,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h000000, d};
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk_bit("bus answer", 1'b1, n < 40);
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic lnk(input int n);
    repeat (n) @(negedge lclk);
  endtask : lnk
  task automatic mon_clr;
    @(posedge clk) clr <= 1'b1;
    lnk(2);
    @(posedge clk) clr <= 1'b0;
  endtask : mon_clr
  // Polls status until the masked bits match
  task automatic poll(input logic [7:0] m, input logic [7:0] w);
    ok = 1'b0;
    repeat (400) if (!ok) begin
      bus(1'b0, `SBF_A_STAT, 8'h00);
      ok = ((rd & m) === w);
    end
  endtask : poll
  task automatic wait_irq;
    int n;
    n = 0;
    while (tx_irq !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_irq
  // ===================================================================
  // Scenarios
  task automatic t_reset;
    chk_bit("txd idle", 1'b1, txd);
    chk_bit("irq idle", 1'b0, tx_irq);
    chk_bit("rts_n", 1'b1, rts_n);
    bus(1'b0, `SBF_A_STAT, 8'h00);
    chk_byte("status", 8'h05, rd);
    bus(1'b0, `SBF_A_FP, 8'h00);
    chk_byte("flag reg read", 8'h00, rd);
    bus(1'b0, 4'hf, 8'h00);
    chk_byte("unmapped read", 8'h00, rd);
    $display("test reset done");
  endtask : t_reset
  task automatic t_enable;
    bus(1'b1, `SBF_A_IM, 8'h02); // Host setup first
    bus(1'b1, `SBF_A_PM, `SBF_PM_SDLC);
    bus(1'b1, `SBF_A_TC, 8'heb);
    bus(1'b1, `SBF_A_CMD, {5'h00, `SBF_CMD_RCRC});
    mon_clr;
    lnk(40);
    chk_bit("rts_n on", 1'b0, rts_n);
    chk_bit("dtr_n on", 1'b0, dtr_n);
    chk_bit("flags", 1'b1, flag_seen);
    chk_byte("flag run", 8'h06, {3'h0, max_run});
    chk_bit("no early irq", 1'b0, tx_irq);
    $display("test enable done");
  endtask : t_enable
  task automatic t_frame;
    mon_clr;
    bus(1'b1, `SBF_A_TXD, 8'hff);
    bus(1'b1, `SBF_A_CMD, {5'h00, `SBF_CMD_REOM});
    wait_irq;
    chk_bit("empty irq", 1'b1, tx_irq);
    bus(1'b1, `SBF_A_CMD, {5'h00, `SBF_CMD_RPEND});
    @(posedge clk);
    @(posedge clk);
    chk_bit("irq cleared", 1'b0, tx_irq);
    poll(8'h08, 8'h08);
    chk_bit("crc starts", 1'b1, ok);
    poll(8'h0c, 8'h04);
    chk_bit("crc ends", 1'b1, ok);
    lnk(24);
    chk_byte("stuffed run", 8'h06, {3'h0, max_run});
    chk_bit("no irq after", 1'b0, tx_irq);
    $display("test frame done");
  endtask : t_frame
  task automatic t_abort;
    mon_clr;
    bus(1'b1, `SBF_A_TXD, 8'h00);
    wait_irq;
    chk_bit("reload irq", 1'b1, tx_irq);
    bus(1'b1, `SBF_A_TXD, 8'h55);
    bus(1'b1, `SBF_A_CMD, {5'h00, `SBF_CMD_ABORT});
    lnk(20);
    chk_bit("abort ones", 1'b1, max_run >= 5'd8 && max_run < 5'd14);
    bus(1'b0, `SBF_A_STAT, 8'h00);
    chk_bit("buffer dropped", 1'b1, rd[0]);
    mon_clr;
    lnk(30);
    chk_bit("flags again", 1'b1, flag_seen);
    chk_byte("flag run again", 8'h06, {3'h0, max_run});
    mon_clr;
    bus(1'b1, `SBF_A_CMD, {5'h00, `SBF_CMD_ABORT});
    lnk(20);
    chk_bit("flag abort", 1'b1, max_run >= 5'd8 && max_run < 5'd14);
    $display("test abort done");
  endtask : t_abort
  task automatic t_break;
    bus(1'b1, `SBF_A_TC, 8'hfb);
    repeat (20) @(posedge clk);
    chk_bit("break spacing", 1'b0, txd);
    bus(1'b1, `SBF_A_TC, 8'he3);
    lnk(20);
    mon_clr;
    lnk(10);
    chk_bit("disabled marking", 1'b1, txd);
    chk_bit("flags stopped", 1'b0, flag_seen);
    $display("test break done");
  endtask : t_break
  // Restarts the remote with flag, address, control, flag
  task automatic rx_start(input logic [7:0] a);
    @(posedge clk);
    rx_go <= 1'b0;
    lnk(2);
    @(posedge clk);
    rx_pat <= {8'h7e, 8'h33, a, 8'h7e};
    rx_go <= 1'b1;
  endtask : rx_start
  task automatic t_receive;
    bus(1'b1, `SBF_A_SA, 8'h5a);
    bus(1'b1, `SBF_A_RC, 8'hc5);
    rx_start(8'h5a);
    poll(8'h20, 8'h20);
    bus(1'b0, `SBF_A_RXD, 8'h00);
    chk_byte("address byte", 8'h5a, rd);
    poll(8'h20, 8'h20);
    bus(1'b0, `SBF_A_RXD, 8'h00);
    chk_byte("control byte", 8'h33, rd);
    rx_start(8'ha5);
    lnk(40);
    bus(1'b0, `SBF_A_STAT, 8'h00);
    chk_bit("foreign dropped", 1'b0, rd[5]);
    $display("test receive done");
  endtask : t_receive
  // ===================================================================
  // Verdict, watchdog and main sequence
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict
  // Tests need about 2500 cycles; twelve times that means a hang
  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    $display("mismatch watchdog expected finish seen hang");
    print_verdict;
  end
  initial begin
    fails = 0;
    tests_run = 0;
    nrst = 1'b0;
    clr = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h00000000;
    rx_go = 1'b0;
    rx_pat = 32'h00000000;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset;
    t_enable;
    t_frame;
    t_abort;
    t_break;
    t_receive;
    print_verdict;
  end
endmodule : tb_sbf_framer
`default_nettype wire

// ### hw/sbf_framer.sv
// Purpose: SDLC bit framer, transmit centred, with a lean receiver
// Assumes: Link clock and rxd are asynchronous pins sampled by clk
// Notes: Registers on Avalon-MM, one wait state per access
//
// The Avalon-MM register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "sbf_map.svh"

// Behaviour
// - Receive shared-zero flags, transmit whole flags
// - Address search drops frames of other stations
// - Flag and station address in own registers
// - Control field passed to host unchanged
// - Reset-CRC command presets generator to ones, only with the SDLC polynomial selected
// - Opening flag clears receive CRC checker
// - Idle or disabled transmitter holds line marking
// - Break drives continuous spacing
// - Enabled idle transmitter sends back-to-back flags
// - Abort sends eight to thirteen ones
// - Abort discards shifting and buffered characters
// - Zero after five ones, frame content only
// - Buffer empty raises transmit interrupt
// - Write or command clears pending interrupt
// - Underrun after content emits frame check
// - No empty interrupt before first write
// - Receive control register bit layout
// - Mode register 0x20 selects SDLC
// - Character length codes decode 5,6,7,8
// - Underrun sends two CRC bytes, then flags
// - Characters leave least significant bit first
module sbf_framer (
  input wire logic clk, // 20 MHz clock
  input wire logic nrst, // Sync reset, low
  input wire logic [5:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [3:0] avs_byteenable, // Lane 0 carries data
  input wire sbf_pkg::sbf_word_t avs_writedata, // Write data
  output var sbf_pkg::sbf_word_t avs_readdata, // Read data
  output var logic avs_waitrequest, // Stall, high
  input wire logic lclk, // Link clock pin
  input wire logic rxd, // Receive data pin
  output var logic txd, // Transmit data
  output var logic rts_n, // Request to send, low
  output var logic dtr_n, // Terminal ready, low
  output var logic tx_irq // Transmit interrupt, high
);
  import sbf_pkg::*;

  // ===================================================================
  // Helpers
  function automatic logic [3:0] sbf_len(input logic [1:0] c);
    logic [3:0] n;
    n = 4'h8;
    unique case (c)
      2'b00: n = 4'h5;
      2'b10: n = 4'h6;
      2'b01: n = 4'h7;
      2'b11: n = 4'h8;
    endcase
    return n;
  endfunction : sbf_len

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic b);
    return {1'b0, c[15:1]} ^ ((c[0] ^ b) ? `SBF_CRC_POLY : 16'h0000);
  endfunction : crc_step

  // ===================================================================
  // Bus slave
  logic [3:0] idx;
  logic wr_en, rd_done;
  logic [7:0] wd;
  logic wr_cmd, wr_rc, wr_data, rd_rxd;
  logic c_abort, c_rpend, c_rcrc, c_reom;
  sbf_word_t rmux;

  assign idx = avs_address[5:2];
  assign wd = avs_writedata[7:0];
  assign wr_en = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign rd_done = avs_read && !avs_waitrequest;
  assign wr_cmd = wr_en && idx == `SBF_A_CMD;
  assign wr_rc = wr_en && idx == `SBF_A_RC;
  assign wr_data = wr_en && idx == `SBF_A_TXD;
  assign rd_rxd = rd_done && idx == `SBF_A_RXD;
  assign c_abort = wr_cmd && wd[2:0] == `SBF_CMD_ABORT;
  assign c_rpend = wr_cmd && wd[2:0] == `SBF_CMD_RPEND;
  assign c_rcrc = wr_cmd && wd[2:0] == `SBF_CMD_RCRC;
  assign c_reom = wr_cmd && wd[2:0] == `SBF_CMD_REOM;

  // One wait state: low in the second cycle of every request
  always_ff @(posedge clk) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  // Read data captured in the first cycle, stable at the answer edge
  always_ff @(posedge clk) begin
    if (!nrst) begin
      avs_readdata <= '0;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= rmux;
    end
  end

  // ===================================================================
  // Software registers
  logic [7:0] im_q, vec_q, rc_q, pm_q, sa_q, fp_q;
  sbf_txctl_t tc_q;
  logic sdlc, tx_on;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      im_q <= 8'h00;
      vec_q <= 8'h00;
      rc_q <= 8'h00;
      pm_q <= 8'h00;
      tc_q <= '0;
      sa_q <= 8'h00;
      fp_q <= `SBF_FLAG_RST;
    end else if (wr_en) begin
      unique case (idx)
        `SBF_A_IM: im_q <= wd;
        `SBF_A_VEC: vec_q <= wd;
        `SBF_A_RC: rc_q <= {wd[7:2], 1'b0, wd[0]};
        `SBF_A_PM: pm_q <= wd;
        `SBF_A_TC: tc_q <= wd;
        `SBF_A_SA: sa_q <= wd;
        `SBF_A_FP: fp_q <= wd;
        default: ;
      endcase
    end
  end

  // Only the exact SDLC mode value lets the framer run
  assign sdlc = pm_q == `SBF_PM_SDLC;
  // Transmitter is useless until mode and enable are both set up
  assign tx_on = tc_q.en && sdlc;

  // Modem controls straight from the control register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rts_n <= 1'b1;
      dtr_n <= 1'b1;
    end else begin
      rts_n <= !tc_q.rts;
      dtr_n <= !tc_q.dtr;
    end
  end

  // ===================================================================
  // Link pin sampling, change accepted when stages two and three agree
  logic [2:0] lc_s_q, rd_s_q;
  logic lc_lv_q, rd_lv_q;
  logic lc_ok, tx_tick, rx_tick, rb;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      lc_s_q <= 3'h0;
      rd_s_q <= 3'h7;
      lc_lv_q <= 1'b0;
      rd_lv_q <= 1'b1;
    end else begin
      lc_s_q <= {lc_s_q[1:0], lclk};
      rd_s_q <= {rd_s_q[1:0], rxd};
      if (lc_s_q[1] == lc_s_q[2]) lc_lv_q <= lc_s_q[2];
      if (rd_s_q[1] == rd_s_q[2]) rd_lv_q <= rd_s_q[2];
    end
  end

  // Transmit on falling link edge, receive on rising
  assign lc_ok = lc_s_q[1] == lc_s_q[2];
  assign tx_tick = lc_ok && lc_lv_q && !lc_s_q[2];
  assign rx_tick = lc_ok && !lc_lv_q && lc_s_q[2] && rc_q[`SBF_RC_EN]
                   && sdlc;
  assign rb = rd_lv_q;

  // ===================================================================
  // Transmit sequencer
  sbf_txst_t st_q, st_d;
  logic [7:0] tb_q, ts_q;
  logic tb_full_q, crc_hi_q, eom_q, txi_pend_q, txi_arm_q;
  logic [3:0] tcnt_q, run_q;
  logic [2:0] tones_q;
  logic [15:0] crc_q, crc_d;
  logic stuff, obit, last, take, tk, acc;
  logic [3:0] ab_len;

  // Run carries across characters; a zero owed by the last content
  // bits goes out ahead of the closing flag, never inside it
  assign stuff = st_q inside {st_data, st_crc, st_flag}
                 && tones_q == 3'd5;
  assign obit = stuff ? 1'b0 : ts_q[0];
  assign last = st_q != st_idle && !stuff && tcnt_q == 4'd1;
  assign acc = tx_tick && st_q == st_data && !stuff && tc_q.crc_en;
  assign crc_d = acc ? crc_step(crc_q, obit) : crc_q;
  assign tk = tx_tick && last && take;
  // Six flag ones already out leave room for only seven abort ones
  assign ab_len = (run_q > 4'd5 || (tx_tick && obit && run_q == 4'd5))
                  ? `SBF_ABORT_SHORT : `SBF_CHAR_BITS;

  // Next character chosen at the last bit of the current one
  always_comb begin
    st_d = st_q;
    take = 1'b0;
    unique case (st_q)
      st_idle: begin
        if (tx_on) st_d = st_flag;
      end
      st_flag, st_data, st_crc, st_abort: begin
        if (!tx_on) begin
          st_d = st_idle;
        end else if (st_q == st_crc && crc_hi_q) begin
          st_d = st_crc;
        end else if (tb_full_q) begin
          st_d = st_data;
          take = 1'b1;
        end else if (st_q == st_data && !eom_q) begin
          st_d = st_crc;
        end else begin
          st_d = st_flag;
        end
      end
    endcase
  end

  // Shifter and state; abort overrides anything in flight
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q <= st_idle;
      ts_q <= 8'h00;
      tcnt_q <= 4'h0;
      crc_hi_q <= 1'b0;
    end else if (c_abort && tx_on && st_q != st_abort) begin
      st_q <= st_abort;
      ts_q <= `SBF_ABORT_ONES;
      tcnt_q <= ab_len; // Repeat abort ignored, run stays short
      crc_hi_q <= 1'b0;
    end else if (tx_tick && st_q != st_idle && !last) begin
      if (!stuff) begin
        ts_q <= {1'b1, ts_q[7:1]};
        tcnt_q <= tcnt_q - 4'd1;
      end
    end else if (tx_tick && (st_q != st_idle || tx_on)) begin
      st_q <= st_d;
      crc_hi_q <= st_d == st_crc && st_q != st_crc;
      tcnt_q <= `SBF_CHAR_BITS;
      if (st_d == st_flag) begin
        ts_q <= fp_q;
      end else if (st_d == st_data) begin
        ts_q <= tb_q;
        tcnt_q <= sbf_len(tc_q.len);
      end else if (st_d == st_crc) begin
        // Frame check goes out inverted, low byte first
        ts_q <= crc_hi_q ? ~crc_q[15:8] : ~crc_d[7:0];
      end
    end
  end

  // Run of contiguous ones sent, for stuffing decisions
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tones_q <= 3'h0;
    end else if (c_abort || st_q inside {st_idle, st_abort}) begin
      tones_q <= 3'h0;
    end else if (tx_tick) begin
      // Flag bits end the run; the owed zero, if any, goes first
      tones_q <= (obit && st_q inside {st_data, st_crc}) ? tones_q + 3'd1
                 : 3'h0;
    end
  end

  // Line driver: break first, then marking when idle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      txd <= 1'b1;
    end else if (tc_q.brk) begin
      txd <= 1'b0;
    end else if (st_q == st_idle) begin
      txd <= 1'b1;
    end else if (tx_tick) begin
      txd <= obit;
    end
  end

  // Generator preset only under SDLC mode and SDLC polynomial
  always_ff @(posedge clk) begin
    if (!nrst) begin
      crc_q <= `SBF_CRC_PRESET;
    end else if (c_rcrc && sdlc && !tc_q.poly) begin
      crc_q <= `SBF_CRC_PRESET;
    end else begin
      crc_q <= crc_d;
    end
  end

  // Buffer: a write landing as the shifter takes it keeps it full
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tb_q <= 8'h00;
      tb_full_q <= 1'b0;
    end else if (c_abort) begin
      tb_full_q <= 1'b0;
    end else if (wr_data) begin
      tb_q <= wd;
      tb_full_q <= 1'b1;
    end else if (tk) begin
      tb_full_q <= 1'b0;
    end
  end

  // End-of-message latch: set by sending CRC, cleared by command
  always_ff @(posedge clk) begin
    if (!nrst) begin
      eom_q <= 1'b1;
    end else if (tx_tick && last && st_q == st_data && st_d == st_crc
                 && !c_abort) begin
      eom_q <= 1'b1;
    end else if (c_reom) begin
      eom_q <= 1'b0;
    end
  end

  // Interrupt arm: only a written character re-arms empty events
  always_ff @(posedge clk) begin
    if (!nrst) begin
      txi_arm_q <= 1'b0;
    end else if (wr_data) begin
      txi_arm_q <= 1'b1;
    end else if (c_rpend) begin
      txi_arm_q <= 1'b0;
    end
  end

  // Pending latch; empty event wins over the command clear
  always_ff @(posedge clk) begin
    if (!nrst) begin
      txi_pend_q <= 1'b0;
    end else if (tk && !wr_data && txi_arm_q && im_q[`SBF_IM_TXIE]) begin
      txi_pend_q <= 1'b1;
    end else if (wr_data || c_rpend) begin
      txi_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_irq <= 1'b0;
    end else begin
      tx_irq <= txi_pend_q;
    end
  end

  // Helper: ones on the line since the last zero, while framing
  always_ff @(posedge clk) begin
    if (!nrst || st_q == st_idle) begin
      run_q <= 4'h0;
    end else if (tx_tick) begin
      run_q <= !obit ? 4'h0 : (run_q == 4'hf ? run_q : run_q + 4'd1);
    end
  end

  // ===================================================================
  // Receiver: 8-bit window so flags never reach the data path
  logic [7:0] rsr_q, rmk_q, rbyte_q, rbyte_d, rval8, rdat_q;
  logic [3:0] rv_q, rbit_q, rlen;
  logic [2:0] rones_q;
  logic [15:0] rcrc_q, rcrc_d;
  logic rframe_q, rfirst_q, rcrcok_q, ravail_q;
  logic rflag, rdv, rdone, rmiss;

  // Sliding match lets a closing zero open the next flag
  assign rflag = {rb, rsr_q[7:1]} == fp_q;
  assign rlen = sbf_len(rc_q[7:6]);
  assign rdv = rx_tick && rframe_q && rv_q == 4'd8 && !rmk_q[0];
  assign rbyte_d = {rsr_q[0], rbyte_q[7:1]};
  assign rdone = rdv && rbit_q == rlen - 4'd1;
  assign rval8 = rbyte_d >> (4'd8 - rlen);
  assign rmiss = rdone && rfirst_q && rc_q[`SBF_RC_ASRCH] && rval8 != sa_q;
  assign rcrc_d = (rdv && rc_q[`SBF_RC_CRCEN]) ? crc_step(rcrc_q, rsr_q[0])
                  : rcrc_q;

  // Window and stuffed-zero marks
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rsr_q <= 8'h00;
      rmk_q <= 8'h00;
      rones_q <= 3'h0;
      rv_q <= 4'h0;
    end else if (rx_tick) begin
      rsr_q <= {rb, rsr_q[7:1]};
      rmk_q <= {!rb && rones_q == 3'd5, rmk_q[7:1]};
      rones_q <= !rb ? 3'h0 : (rones_q == 3'd7 ? rones_q : rones_q + 3'd1);
      rv_q <= rflag ? 4'h0 : (rv_q == 4'd8 ? rv_q : rv_q + 4'd1);
    end
  end

  // Frame tracking, address filter and checker
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rframe_q <= 1'b0;
      rfirst_q <= 1'b0;
      rbit_q <= 4'h0;
      rbyte_q <= 8'h00;
      rcrc_q <= `SBF_CRC_PRESET;
      rcrcok_q <= 1'b0;
    end else if (wr_rc && wd[`SBF_RC_HUNT]) begin
      rframe_q <= 1'b0;
    end else if (rx_tick) begin
      rcrc_q <= rcrc_d;
      if (rdv) begin
        rbyte_q <= rbyte_d;
        rbit_q <= rdone ? 4'h0 : rbit_q + 4'd1;
        if (rdone) rfirst_q <= 1'b0;
      end
      if (rmiss) rframe_q <= 1'b0;
      if (rflag) begin
        rframe_q <= 1'b1;
        rfirst_q <= 1'b1;
        rbit_q <= 4'h0;
        rcrc_q <= `SBF_CRC_PRESET;
        if (rframe_q && !rfirst_q) rcrcok_q <= rcrc_d == `SBF_CRC_GOOD;
      end
      if (rb && rones_q == 3'd6) rframe_q <= 1'b0;
    end
  end

  // Every accepted byte, control field included, goes out as is
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdat_q <= 8'h00;
      ravail_q <= 1'b0;
    end else if (rdone && !rmiss) begin
      rdat_q <= rval8;
      ravail_q <= 1'b1;
    end else if (rd_rxd) begin
      ravail_q <= 1'b0;
    end
  end

  // ===================================================================
  // Read mux
  always_comb begin
    rmux = '0;
    unique case (idx)
      `SBF_A_VEC: rmux[7:0] = vec_q;
      `SBF_A_STAT: rmux[7:0] = {rframe_q, rcrcok_q, ravail_q,
                                st_q == st_abort, st_q == st_crc, eom_q,
                                txi_pend_q, !tb_full_q};
      `SBF_A_RXD: rmux[7:0] = rdat_q;
      default: rmux = '0;
    endcase
  end

  // ===================================================================
  // Assertions
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  a_mark_idle: assert property (
    st_q == st_idle && !tc_q.brk |=> txd)
    else $error("line not marking while idle");
  a_break_space: assert property (
    tc_q.brk |=> !txd)
    else $error("break not spacing");
  a_ones_bound: assert property (
    st_q != st_idle |-> run_q < 4'd14)
    else $error("fourteen or more ones sent");
  a_zero_stuff: assert property (
    tx_tick && stuff && !tc_q.brk |=> !txd)
    else $error("no zero after five ones");
  a_crc_preset: assert property (
    c_rcrc && sdlc && !tc_q.poly |=> crc_q == `SBF_CRC_PRESET)
    else $error("generator not preset");
  a_abort_flush: assert property (
    c_abort && tx_on && st_q != st_abort
    |=> st_q == st_abort && !tb_full_q && ts_q == 8'hff)
    else $error("abort did not flush");
  a_int_clear: assert property (
    wr_data |=> !txi_pend_q)
    else $error("write left interrupt pending");
  a_int_quiet: assert property (
    !txi_arm_q && !txi_pend_q && !wr_data |=> !txi_pend_q)
    else $error("interrupt without written character");
  a_crc_follow: assert property (
    tx_tick && last && st_q == st_data && !tb_full_q && !eom_q && tx_on
    && !c_abort |=> st_q == st_crc && eom_q)
    else $error("underrun did not start frame check");
  a_rx_crc_clear: assert property (
    rx_tick && rflag && !(wr_rc && wd[`SBF_RC_HUNT])
    |=> rcrc_q == `SBF_CRC_PRESET && rframe_q)
    else $error("checker not cleared at flag");
  a_addr_drop: assert property (
    rx_tick && rmiss && !rflag && !(wr_rc && wd[`SBF_RC_HUNT])
    |=> !rframe_q && !$rose(ravail_q))
    else $error("foreign frame kept");
endmodule : sbf_framer
`default_nettype wire

// ### hw/sbf_map.svh
// Purpose: Offsets, field positions and constants of the bit framer
// Assumes: Included by its bare name after the package
// Notes: Word index of each register is avs_address[5:2]
`ifndef SBF_MAP_SVH
`define SBF_MAP_SVH
// =====================================================================
// Register word indexes
`define SBF_A_CMD 4'h0
`define SBF_A_IM 4'h1
`define SBF_A_VEC 4'h2
`define SBF_A_RC 4'h3
`define SBF_A_PM 4'h4
`define SBF_A_TC 4'h5
`define SBF_A_SA 4'h6
`define SBF_A_FP 4'h7
`define SBF_A_TXD 4'h8
`define SBF_A_STAT 4'h9
`define SBF_A_RXD 4'ha
// =====================================================================
// Command codes, written to bits 2:0 of the command register
`define SBF_CMD_ABORT 3'h1
`define SBF_CMD_RPEND 3'h5
`define SBF_CMD_RCRC 3'h6
`define SBF_CMD_REOM 3'h7
// =====================================================================
// Field positions
`define SBF_IM_TXIE 1
`define SBF_RC_EN 0
`define SBF_RC_ASRCH 2
`define SBF_RC_CRCEN 3
`define SBF_RC_HUNT 4
`define SBF_RC_AUTO 5
// =====================================================================
// Values
`define SBF_PM_SDLC 8'h20
`define SBF_FLAG_RST 8'h7e
`define SBF_CRC_PRESET 16'hffff
`define SBF_CRC_POLY 16'h8408
`define SBF_CRC_GOOD 16'hf0b8
`define SBF_ABORT_ONES 8'hff
`define SBF_CHAR_BITS 4'h8
`define SBF_ABORT_SHORT 4'h7
`endif

// ### hw/sbf_pkg.sv
// Purpose: Types shared by the bit framer
// Assumes: Nothing
// Notes: Transmit control struct mirrors the register bit order
package sbf_pkg;
  // ===================================================================
  // Bus word and transmit sequencer states
  typedef logic [31:0] sbf_word_t;
  typedef enum logic [4:0] {
    st_idle = 5'b00001,
    st_flag = 5'b00010,
    st_data = 5'b00100,
    st_crc = 5'b01000,
    st_abort = 5'b10000
  } sbf_txst_t;
  // Transmit control register, bit 7 down to bit 0
  typedef struct packed {
    logic dtr;
    logic [1:0] len;
    logic brk;
    logic en;
    logic poly;
    logic rts;
    logic crc_en;
  } sbf_txctl_t;
endpackage : sbf_pkg
